/* hw/wdit_top.sv */
// top: watchdog interval timer with wishbone registers
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module wdit_top
  import wdit_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic POR_I,
  input wire logic PCLK_EN_I,
  input wire logic WDOSC_I,
  input wire logic PWRDN_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WDT_RST_O,
  output logic IRQ_O,
  output logic [7:0] COUNT_O
);
  // ==========================================================
  // reset handling
  // SRST_I is the system bus reset; it covers only bus logic.
  // timer state is reset by POR_I alone, so its own timeout
  // reset (fed back into SRST_I) does not wipe it.
  logic por; // synchronised power-on reset
  logic por_m;
  always_ff @(posedge CLK_SYS_I) begin
    por_m <= POR_I;
    por <= por_m;
  end

  // ==========================================================
  // watchdog oscillator edge detect
  // the delayed copy turns each slow rising edge into one tick
  logic osc_m, osc_s, osc_d; // sync chain and delayed copy
  always_ff @(posedge CLK_SYS_I) begin
    osc_m <= WDOSC_I;
    osc_s <= osc_m;
    osc_d <= osc_s;
  end

  // ==========================================================
  // registers
  logic [15:0] ctrl; // control word
  wdit_stat_t stat; // sticky status
  logic [1:0] mask; // interrupt mask
  logic [7:0] cnt; // down counter
  logic wr, rd, req;
  logic hit;
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // a write lands at the edge where the master sees ack high,
  // so a master that gives up early leaves the registers alone
  assign wr = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I;
  assign rd = req && !WB_WE_I;
  assign hit = (WB_ADR_I == WDIT_ADDR_CTRL) || (WB_ADR_I == WDIT_ADDR_FEED)
    || (WB_ADR_I == WDIT_ADDR_STAT) || (WB_ADR_I == WDIT_ADDR_MASK);

  logic rsten, run, clksel;
  logic [2:0] tap_sel;
  logic [7:0] reload;
  assign rsten = ctrl[WDIT_CTRL_RSTEN];
  assign run = ctrl[WDIT_CTRL_RUN];
  assign clksel = ctrl[WDIT_CTRL_CLKSEL];
  assign tap_sel = ctrl[WDIT_CTRL_TAP_LO +: 3];
  assign reload = ctrl[WDIT_CTRL_RELOAD_LO +: 8];

  // control register write, low byte lanes
  always_ff @(posedge CLK_SYS_I) begin
    if (por) begin
      ctrl <= WDIT_CTRL_RST;
    end else if (wr && WB_ADR_I == WDIT_ADDR_CTRL) begin
      if (WB_SEL_I[0]) begin
        ctrl[7:0] <= WB_DAT_I[7:0];
      end
      if (WB_SEL_I[1]) begin
        ctrl[15:8] <= WB_DAT_I[15:8];
      end
    end
  end

  // mask register
  always_ff @(posedge CLK_SYS_I) begin
    if (por) begin
      mask <= WDIT_MASK_RST;
    end else if (wr && WB_ADR_I == WDIT_ADDR_MASK && WB_SEL_I[0]) begin
      mask <= WB_DAT_I[1:0];
    end
  end

  // ==========================================================
  // feed sequencer
  wdit_feed_t feed_st;
  logic feed_wr; // a byte write to the feed register
  logic feed_ok; // correct two-key sequence done
  // lane 0 only; upper lanes of a feed write are ignored
  assign feed_wr = wr && WB_ADR_I == WDIT_ADDR_FEED && WB_SEL_I[0];
  // key check; any other bus write aborts
  always_ff @(posedge CLK_SYS_I) begin
    if (por) begin
      feed_st <= FEED_IDLE;
    end else if (wr) begin
      case (feed_st)
        FEED_IDLE: begin
          if (feed_wr && WB_DAT_I[7:0] == WDIT_KEY1) begin
            feed_st <= FEED_KEY1;
          end
        end
        FEED_KEY1: begin
          feed_st <= FEED_IDLE;
        end
        default: begin
          feed_st <= FEED_IDLE;
        end
      endcase
    end
  end
  assign feed_ok = feed_st == FEED_KEY1 && feed_wr
    && WB_DAT_I[7:0] == WDIT_KEY2;

  // ==========================================================
  // prescaler source
  logic tick; // one prescaler input pulse
  always_comb begin
    if (clksel) begin
      tick = run && osc_s && !osc_d;
    end else begin
      tick = run && PCLK_EN_I && !PWRDN_I;
    end
  end

  logic tap_pulse;
  wdit_prescaler #(
    .WIDTH(WDIT_PRE_W)
  ) wdit_prescaler_i (
    .clk_i(CLK_SYS_I),
    .rst_i(por),
    .tick_i(tick),
    .clear_i(feed_ok),
    .tap_i(tap_sel),
    .tap_o(tap_pulse)
  );

  // ==========================================================
  // down counter
  // feed outranks underflow, so a last-moment feed still saves us
  logic under; // one-cycle underflow event
  assign under = tap_pulse && cnt == 8'h00;
  always_ff @(posedge CLK_SYS_I) begin
    if (por) begin
      cnt <= 8'hFF;
    end else if (feed_ok) begin
      cnt <= reload;
    end else if (under) begin
      cnt <= reload;
    end else if (tap_pulse) begin
      cnt <= cnt - 8'h01;
    end
  end

  // ==========================================================
  // reset pulse generator
  logic [3:0] rst_cnt; // cycles of reset pulse left
  always_ff @(posedge CLK_SYS_I) begin
    if (por) begin
      rst_cnt <= 4'h0;
    end else if (under && rsten) begin
      rst_cnt <= WDIT_RST_CYC;
    end else if (rst_cnt != 4'h0) begin
      rst_cnt <= rst_cnt - 4'h1;
    end
  end
  assign WDT_RST_O = rst_cnt != 4'h0;

  // ==========================================================
  // sticky status; set wins over read-clear
  // the read clears at the edge where its answer data and ack are registered, one edge before the master samples ack
  logic stat_rd;
  assign stat_rd = rd && WB_ADR_I == WDIT_ADDR_STAT;
  always_ff @(posedge CLK_SYS_I) begin
    if (por) begin
      stat <= '0;
    end else begin
      stat.ivl_flag <= (under && !rsten) || (stat.ivl_flag && !stat_rd);
      stat.tmo_rst <= (under && rsten) || (stat.tmo_rst && !stat_rd);
    end
  end
  assign IRQ_O = |(stat & mask);

  // ==========================================================
  // bus answer: one wait state, unmapped reads zero
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= req;
      WB_DAT_O <= 32'h0000_0000;
      if (rd && hit) begin
        case (WB_ADR_I)
          WDIT_ADDR_CTRL: WB_DAT_O <= {16'h0000, ctrl};
          WDIT_ADDR_FEED: WB_DAT_O <= {24'h000000, cnt};
          WDIT_ADDR_STAT: WB_DAT_O <= {30'h0, stat};
          WDIT_ADDR_MASK: WB_DAT_O <= {30'h0, mask};
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign COUNT_O = cnt;

  // ==========================================================
  // checks
  default clocking @(posedge CLK_SYS_I); endclocking
  // the pin term covers the cycles before the synchronised copy
  // settles, while timer state is still unknown
  default disable iff (POR_I || por);

  rst_pulse_a: assert property (
    (under && rsten) |=> WDT_RST_O [*8])
    else $error("timeout reset pulse short");
  rst_end_a: assert property (
    $fell(WDT_RST_O) |-> $past(under && rsten, 9))
    else $error("timeout reset pulse end wrong");
  step_tap_a: assert property (
    (!tap_pulse && !feed_ok) |=> cnt == $past(cnt))
    else $error("counter moved without tap");
  dec_one_a: assert property (
    (tap_pulse && !feed_ok && cnt != 8'h00) |=> cnt == $past(cnt) - 8'h01)
    else $error("counter step not one");
  src_sel_a: assert property (
    (!clksel && !(PCLK_EN_I && run)) |-> !tick)
    else $error("tick without peripheral clock");
  pwrdn_stop_a: assert property (
    (!clksel && PWRDN_I) |-> !tick)
    else $error("ran in power-down");
  ivl_flag_a: assert property (
    (under && !rsten) |=> stat.ivl_flag && !WDT_RST_O)
    else $error("interval flag missing");
  feed_reload_a: assert property (
    feed_ok |=> cnt == $past(reload))
    else $error("feed did not reload");
  one_write_a: assert property (
    $rose(feed_st == FEED_KEY1) |-> $past(feed_wr)
      && $past(WB_DAT_I[7:0]) == WDIT_KEY1)
    else $error("feed armed without first key");
  por_keep_a: assert property (
    (SRST_I && !por) |=> $stable(ctrl) || $past(wr))
    else $error("state lost on soft reset");
  irq_rise_a: assert property (
    $rose(IRQ_O) |-> $past(under) || $past(wr))
    else $error("irq rose without cause");
  stat_clr_a: assert property (
    (stat_rd && !under) |=> stat == '0)
    else $error("status not cleared by read");
  // bus answer one cycle after request
  bus_ack_a: assert property (
    (req && !SRST_I) |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus answer timing wrong");

  // main scenarios reached
  cov_feed_c: cover property (feed_ok);
  cov_osc_c: cover property (clksel && tick);
  cov_rst_c: cover property (under && rsten);
  cov_ivl_c: cover property (under && !rsten ##1 IRQ_O);
endmodule : wdit_top

/* hw/wdit_pkg.sv */
// package: constants and types for the watchdog interval timer
package wdit_pkg;
  // ==========================================================
  // register map (byte addresses, one word each)
  localparam logic [3:0] WDIT_ADDR_CTRL = 4'h0;   // control
  localparam logic [3:0] WDIT_ADDR_FEED = 4'h4;   // feed keys
  localparam logic [3:0] WDIT_ADDR_STAT = 4'h8;   // sticky status
  localparam logic [3:0] WDIT_ADDR_MASK = 4'hC;   // interrupt mask
  localparam logic [3:0] WDIT_ADDR_CNT  = 4'h0 + 4'h0; // unused alias
  // control bit positions
  localparam int WDIT_CTRL_RSTEN = 0;  // watchdog_reset_enable
  localparam int WDIT_CTRL_RUN   = 1;  // counter running
  localparam int WDIT_CTRL_CLKSEL = 2; // 1 = watchdog oscillator
  localparam int WDIT_CTRL_TAP_LO = 4; // tap select, 3 bits
  localparam int WDIT_CTRL_RELOAD_LO = 8; // reload value, 8 bits
  // reset values
  localparam logic [15:0] WDIT_CTRL_RST = 16'hFF70;
  localparam logic [1:0] WDIT_MASK_RST = 2'h0;
  // feed keys, written back to back
  localparam logic [7:0] WDIT_KEY1 = 8'hA5;
  localparam logic [7:0] WDIT_KEY2 = 8'h5A;
  // widths
  localparam int WDIT_PRE_W = 12;
  localparam int WDIT_CNT_W = 8;
  // reset pulse length in system cycles
  localparam logic [3:0] WDIT_RST_CYC = 4'h8;
  // feed sequencer states
  typedef enum logic [1:0] {
    FEED_IDLE = 2'b01,
    FEED_KEY1 = 2'b10
  } wdit_feed_t;
  // status bits: underflow flag, timeout reset seen
  typedef struct packed {
    logic tmo_rst;
    logic ivl_flag;
  } wdit_stat_t;
endpackage : wdit_pkg

/* hw/wdit_prescaler.sv */
// prescaler: 12-bit counter with tap-select pulse output
`timescale 1ns/1ps
module wdit_prescaler
  import wdit_pkg::*;
#(
  parameter int WIDTH = WDIT_PRE_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic [2:0] tap_i,
  output logic tap_o
);
  // ==========================================================
  // counter
  logic [WIDTH-1:0] pre; // free count of source ticks
  logic [WIDTH-1:0] next_pre;
  logic [3:0] bit_idx; // tap bit, spread over the width
  assign next_pre = pre + {{(WIDTH-1){1'b0}}, 1'b1};
  assign bit_idx = {tap_i, 1'b0} + 4'h1;
  // count on each source tick, a good feed clears it
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      pre <= '0;
    end else if (tick_i) begin
      pre <= next_pre;
    end
  end
  // pulse when the selected bit wraps; taps are 2^2 .. 2^12
  always_comb begin
    if (bit_idx >= 4'(WIDTH)) begin
      // taps past the top bit fall back to a full wrap
      tap_o = tick_i && !clear_i && (next_pre == '0);
    end else begin
      tap_o = tick_i && !clear_i && pre[bit_idx] && !next_pre[bit_idx];
    end
  end
endmodule : wdit_prescaler

/* tb/test_wdit_top.sv */
// bench: self-checking test of the watchdog interval timer
`timescale 1ns/1ps
module test_wdit_top;
  import wdit_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic srst = 1'b1; // bus reset
  logic por = 1'b1; // power-on reset
  logic pclk_en = 1'b1; // one tick per cycle
  logic wdosc = 1'b0;
  logic pwrdn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic wrst;
  logic irq;
  logic [7:0] cnt;
  logic [7:0] snap; // count seen before a wait
  logic [7:0] bad; // random wrong key
  logic [31:0] exp_q[$]; // expected read data, oldest first
  int error_cnt = 0;
  int samples_checked = 0;
  int n;
  int t;

  wdit_top wdit_top_i (.CLK_SYS_I(clk), .SRST_I(srst), .POR_I(por),
    .PCLK_EN_I(pclk_en), .WDOSC_I(wdosc), .PWRDN_I(pwrdn),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .WDT_RST_O(wrst), .IRQ_O(irq), .COUNT_O(cnt));

  // ==========================================================
  // clock
  initial forever #2 clk = ~clk;

  // ==========================================================
  // helpers
  task automatic report_and_stop();
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic fail(input string m);
    error_cnt++;
    $display("CHECK FAILED t=%0t %s", $time, m);
  endtask : fail

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    samples_checked++;
    if (g !== e) fail(m);
  endtask : chk

  // classic cycle; held until ack is sampled, then released
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail("bus answer missing");
      report_and_stop();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd

  task automatic feed(input logic [7:0] k2);
    wb(1'b1, WDIT_ADDR_FEED, {24'h0, WDIT_KEY1});
    wb(1'b1, WDIT_ADDR_FEED, {24'h0, k2});
  endtask : feed

  // bounded wait: 0 irq high, 1 reset high, 2 count moved from snap
  task automatic wait_for(input int which, input int lim, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!((which == 0 && irq === 1'b1) ||
                 (which == 1 && wrst === 1'b1) ||
                 (which == 2 && cnt !== snap)) && k < lim);
    if (k >= lim) begin
      fail("wait ran out");
      report_and_stop();
    end
  endtask : wait_for

  // ==========================================================
  // monitor: every read answer against the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) fail("unexpected read answer");
      else chk(rdat, exp_q.pop_front(), "read data");
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hC48BF382));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    por <= 1'b0;
    repeat (4) @(posedge clk);
    rd(WDIT_ADDR_CTRL, 32'h0000FF70);
    rd(WDIT_ADDR_STAT, 32'h0);
    rd(WDIT_ADDR_MASK, 32'h0);
    rd(4'h2, 32'h0); // unmapped place reads zero
    chk({24'h0, cnt}, 32'h000000FF, "count default");
    // tap select sets the step period, 2^(2*tap+2) ticks, checked for taps 0 to 2
    for (t = 0; t < 3; t++) begin
      wb(1'b1, WDIT_ADDR_CTRL, 32'h0000FF02 | (t << 4));
      snap = cnt;
      wait_for(2, 300, n);
      snap = cnt;
      wait_for(2, 300, n);
      chk(n, 32'h4 << (2 * t), "step period");
    end
    // interval mode raises flag and interrupt on underflow
    wb(1'b1, WDIT_ADDR_MASK, 32'h1);
    wb(1'b1, WDIT_ADDR_CTRL, 32'h00000A02);
    feed(WDIT_KEY2);
    @(negedge clk);
    chk({24'h0, cnt}, 32'h0000000A, "feed reload");
    wait_for(0, 200, n);
    chk(n > 40, 32'h1, "underflow time");
    rd(WDIT_ADDR_STAT, 32'h1);
    @(negedge clk);
    chk(irq, 32'h0, "irq after read");
    wb(1'b1, WDIT_ADDR_MASK, 32'h0);
    repeat (100) @(negedge clk);
    chk(irq, 32'h0, "masked irq");
    rd(WDIT_ADDR_STAT, 32'h1);
    // broken feeds leave the count running
    wb(1'b1, WDIT_ADDR_CTRL, 32'h0000FF02);
    feed(WDIT_KEY2);
    repeat (100) @(negedge clk);
    bad = 8'($urandom);
    if (bad == WDIT_KEY2) bad = 8'h00;
    feed(bad);
    wb(1'b1, WDIT_ADDR_FEED, {24'h0, WDIT_KEY1});
    wb(1'b1, WDIT_ADDR_MASK, 32'h0);
    wb(1'b1, WDIT_ADDR_FEED, {24'h0, WDIT_KEY2});
    @(negedge clk);
    chk(cnt < 8'hF0, 32'h1, "bad feed reloaded");
    feed(WDIT_KEY2);
    @(negedge clk);
    chk({24'h0, cnt}, 32'h000000FF, "good feed");
    // no ticks, or power-down on peripheral clock, stops the count
    @(posedge clk);
    pwrdn <= 1'b1;
    @(negedge clk);
    snap = cnt;
    repeat (60) @(negedge clk);
    chk({24'h0, cnt}, {24'h0, snap}, "powered down");
    @(posedge clk);
    pwrdn <= 1'b0;
    pclk_en <= 1'b0;
    repeat (60) @(negedge clk);
    chk({24'h0, cnt}, {24'h0, snap}, "no tick");
    // oscillator source keeps running in power-down; fast pin here
    wb(1'b1, WDIT_ADDR_CTRL, 32'h0000FF06);
    pwrdn <= 1'b1;
    repeat (60) begin
      repeat (10) @(posedge clk);
      wdosc <= ~wdosc;
    end
    @(negedge clk);
    chk(cnt != snap, 32'h1, "oscillator source");
    // reset enable: underflow gives an 8-cycle system reset
    @(posedge clk);
    pwrdn <= 1'b0;
    pclk_en <= 1'b1;
    wb(1'b1, WDIT_ADDR_CTRL, 32'h00000503);
    feed(WDIT_KEY2);
    wait_for(1, 200, n);
    n = 0;
    while (wrst === 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(n, {28'h0, WDIT_RST_CYC}, "reset pulse");
    rd(WDIT_ADDR_STAT, 32'h2);
    rd(WDIT_ADDR_CTRL, 32'h00000503);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd(WDIT_ADDR_CTRL, 32'h00000503);
    por <= 1'b1;
    repeat (4) @(posedge clk);
    por <= 1'b0;
    repeat (4) @(posedge clk);
    rd(WDIT_ADDR_CTRL, 32'h0000FF70);
    repeat (4) @(posedge clk);
    chk(exp_q.size(), 32'h0, "reads unanswered");
    report_and_stop();
  end
endmodule : test_wdit_top
